// File: emc_pin_ctrl.sv
`default_nettype none
// How it works
// RULE1 - two select pins pick normal, adapter, probe or reserved test mode
// RULE2 - adapter mode releases processor pins, keeps serial, host, selects and ports; code floats serial transmit in adapter mode
// RULE3 - probe mode floats every output of the device
// RULE4 - board never selects the reserved test mode in use
// RULE5 - external reset initialises configuration, bounds, serial, ports and host logic
// RULE6 - normal mode stretches external reset through a one-shot
// RULE7 - adapter mode bypasses the one-shot; pin drives internal reset
// RULE8 - crystal oscillator off in adapter and probe modes
// RULE9 - emulator drives memory request and address 18 on shared pins
// RULE10 - adapter mode turns interrupt-0 into an open-drain output
// RULE11 - sleep or halt drives read and write strobes high when selected
// RULE12 - rom and ram selects forced high in sleep or halt
// RULE13 - sleep or halt floats bus read/write and io select when selected
// RULE14 - power-down floats all address lines and data lines; code keeps the addr18 pin driving when it carries the timer
// RULE15 - host emulation logic disabled during power-down
// RULE16 - host receive interrupt set within two clocks of stop
// RULE17 - host receive interrupt cleared within two clocks of buffer/status read
// RULE18 - serial clock undivided after reset; software may select divide-by-two
// RULE19 - select pins held constant; mode treated as static
module emc_pin_ctrl
	import emc_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic NRST,
	// mode select pins
	input wire logic MODE_SELECT_LOW,
	input wire logic MODE_SELECT_HIGH,
	// processor state and pin-mux selections
	input wire logic CPU_SLEEP,
	input wire logic CPU_HALT,
	input wire logic MUX_MEM_STROBES,
	input wire logic MUX_IO_SELECT,
	input wire logic ADDR18_AS_ADDR,
	// internal core signals to the pins
	input wire logic [emc_pkg::ADDR_W-1:0] CORE_ADDR,
	input wire logic CORE_ADDR_OE,
	input wire logic [emc_pkg::DATA_W-1:0] CORE_DATA,
	input wire logic CORE_DATA_OE,
	input wire logic CORE_TIMER_OUT,
	input wire logic CORE_RD_N,
	input wire logic CORE_WR_N,
	input wire logic CORE_CTRL_OE,
	input wire logic CORE_MEM_READ_STROBE_N,
	input wire logic CORE_MEM_WRITE_STROBE_N,
	input wire logic CORE_ROM_SELECT_N,
	input wire logic CORE_RAM_SELECT_N,
	input wire logic CORE_IO_SELECT_N,
	input wire logic CORE_SERIAL_TX,
	input wire logic CORE_INT0_PULL,
	// host receive events
	input wire logic HOST_RX_STOP,
	input wire logic HOST_READ_STROBE_N,
	input wire logic HOST_READ_RX_OR_STATUS,
	// software serial clock divide request
	input wire logic SER_DIV2_REQ,
	// address, data and addr18/timer pin
	output logic [emc_pkg::ADDR_W-1:0] ADDR_O,
	output logic [emc_pkg::ADDR_W-1:0] ADDR_OE,
	output logic [emc_pkg::DATA_W-1:0] DATA_O,
	output logic [emc_pkg::DATA_W-1:0] DATA_OE,
	// bus strobes
	output logic RD_N_O,
	output logic RD_N_OE,
	output logic WR_N_O,
	output logic WR_N_OE,
	// chip selects and memory strobes
	output logic MEMORY_READ_STROBE_O,
	output logic MEMORY_READ_STROBE_OE,
	output logic MEMORY_WRITE_STROBE_O,
	output logic MEMORY_WRITE_STROBE_OE,
	output logic ROM_SELECT_O,
	output logic ROM_SELECT_OE,
	output logic RAM_SELECT_O,
	output logic RAM_SELECT_OE,
	output logic IO_SELECT_O,
	output logic IO_SELECT_OE,
	// serial transmit
	output logic SERIAL_TX_O,
	output logic SERIAL_TX_OE,
	// interrupt-0 pin, open drain in adapter mode
	output logic INT0_O,
	output logic INT0_OE,
	// device-level controls
	output logic OSC_ENABLE,
	output logic INT_RESET_N,
	output logic HOST_EMU_ENABLE,
	output logic HOST_RX_INT,
	output logic SER_CLK_ENABLE
);
	import emc_pkg::*;

	typedef enum logic [3:0] {
		EMC_NORMAL = 4'h1,
		EMC_ADAPTER = 4'h2,
		EMC_PROBE = 4'h4,
		EMC_TEST = 4'h8
	} emc_mode_t;

	// decode of the select pins; used for the registered mode and the bypass
	function automatic emc_mode_t decode_mode(input logic [1:0] sel);
		case (sel)
			MODE_NORMAL: decode_mode = EMC_NORMAL;
			MODE_ADAPTER: decode_mode = EMC_ADAPTER;
			MODE_PROBE: decode_mode = EMC_PROBE;
			default: decode_mode = EMC_TEST;
		endcase
	endfunction : decode_mode

	emc_mode_t mode_reg;
	emc_mode_t mode_next;
	logic rx_int_reg;
	logic rx_int_next;
	logic div2_reg;
	logic div_phase_reg;
	logic [ADDR_W-1:0] addr_q_reg;
	logic [DATA_W-1:0] data_q_reg;
	logic int_rst_n;
	logic [1:0] sel_pins;
	logic pin_adapter;
	logic is_normal;
	logic is_adapter;
	logic is_probe;
	logic pwr_down;
	logic drive_ok;
	logic rx_clear;
	logic [ADDR_W-1:0] addr_word;

	// mode pins held static by the board, so the pin decode feeds the bypass directly
	assign sel_pins = {MODE_SELECT_HIGH, MODE_SELECT_LOW}; // [RULE1] [RULE19]
	assign pin_adapter = (decode_mode(sel_pins) == EMC_ADAPTER);
	assign mode_next = decode_mode(sel_pins);

	emc_reset_oneshot #(
		.STRETCH(RESET_STRETCH_CYCLES)
	) u_oneshot (
		.clk(CORE_CLK),
		.nrst(NRST),
		.bypass(pin_adapter), // [RULE6] [RULE7]
		.int_rst_n(int_rst_n)
	);

	// registered mode; test mode is treated like probe, all pins released
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			mode_reg <= EMC_PROBE;
		end else begin
			mode_reg <= mode_next;
		end
	end

	assign is_normal = (mode_reg == EMC_NORMAL);
	assign is_adapter = (mode_reg == EMC_ADAPTER);
	assign is_probe = !is_normal && !is_adapter; // [RULE4]
	assign pwr_down = CPU_SLEEP | CPU_HALT;
	// processor pins are only ours in normal mode, outside reset
	assign drive_ok = is_normal && int_rst_n; // [RULE2] [RULE5]

	// data outputs registered; addr18 carries the timer when not selected as address
	assign addr_word = {CORE_ADDR[ADDR_W-1:ADDR18_BIT+1],
		ADDR18_AS_ADDR ? CORE_ADDR[ADDR18_BIT] : CORE_TIMER_OUT,
		CORE_ADDR[ADDR18_BIT-1:0]};
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			addr_q_reg <= '0;
			data_q_reg <= '0;
		end else begin
			addr_q_reg <= addr_word;
			data_q_reg <= CORE_DATA;
		end
	end
	assign ADDR_O = addr_q_reg;
	assign DATA_O = data_q_reg;

	// address floats in adapter (emulator drives it), probe, power-down; timer may still run
	genvar gi;
	generate
		for (gi = 0; gi < ADDR_W; gi++) begin : g_addr_oe
			if (gi == ADDR18_BIT) begin : g_a18
				// timer output still drives in power-down when the pin is not an address
				assign ADDR_OE[gi] = drive_ok && (ADDR18_AS_ADDR ? (CORE_ADDR_OE && !pwr_down)
					: 1'b1); // [RULE9] [RULE14]
			end else begin : g_an
				assign ADDR_OE[gi] = drive_ok && CORE_ADDR_OE && !pwr_down; // [RULE14]
			end
		end
	endgenerate
	assign DATA_OE = {DATA_W{drive_ok && CORE_DATA_OE && !pwr_down}}; // [RULE14] [RULE3]

	// bus strobes released in sleep or halt
	assign RD_N_O = CORE_RD_N;
	assign WR_N_O = CORE_WR_N;
	assign RD_N_OE = drive_ok && CORE_CTRL_OE && !pwr_down; // [RULE13]
	assign WR_N_OE = RD_N_OE; // [RULE13]

	// memory strobes: in adapter the emulator owns the shared request pin
	assign MEMORY_READ_STROBE_O = pwr_down ? 1'b1 : CORE_MEM_READ_STROBE_N; // [RULE11]
	assign MEMORY_WRITE_STROBE_O = pwr_down ? 1'b1 : CORE_MEM_WRITE_STROBE_N; // [RULE11]
	assign MEMORY_READ_STROBE_OE = drive_ok && MUX_MEM_STROBES; // [RULE9] [RULE2]
	assign MEMORY_WRITE_STROBE_OE = !is_probe && int_rst_n && MUX_MEM_STROBES;

	// chip selects stay ours in adapter mode
	assign ROM_SELECT_O = pwr_down ? 1'b1 : CORE_ROM_SELECT_N; // [RULE12]
	assign RAM_SELECT_O = pwr_down ? 1'b1 : CORE_RAM_SELECT_N; // [RULE12]
	assign ROM_SELECT_OE = !is_probe; // [RULE2] [RULE3]
	assign RAM_SELECT_OE = !is_probe;
	assign IO_SELECT_O = CORE_IO_SELECT_N;
	assign IO_SELECT_OE = !is_probe && MUX_IO_SELECT && !pwr_down; // [RULE13]

	// serial transmit floats in adapter (processor peripheral) and probe
	assign SERIAL_TX_O = CORE_SERIAL_TX;
	assign SERIAL_TX_OE = drive_ok; // [RULE2]

	// interrupt-0 only pulls low, and only in adapter mode
	assign INT0_O = 1'b0;
	assign INT0_OE = is_adapter && CORE_INT0_PULL; // [RULE10]

	// oscillator runs only in normal mode; test mode counted off too
	assign OSC_ENABLE = is_normal; // [RULE8]
	assign INT_RESET_N = int_rst_n; // [RULE5]
	assign HOST_EMU_ENABLE = int_rst_n && !pwr_down && !is_probe; // [RULE15]

	// receive interrupt: one cycle after stop; set wins over clear
	assign rx_clear = !HOST_READ_STROBE_N && HOST_READ_RX_OR_STATUS;
	assign rx_int_next = !HOST_EMU_ENABLE ? 1'b0 :
		HOST_RX_STOP ? 1'b1 : // [RULE16]
		rx_clear ? 1'b0 : rx_int_reg; // [RULE17]
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rx_int_reg <= 1'b0;
		end else begin
			rx_int_reg <= rx_int_next;
		end
	end
	assign HOST_RX_INT = rx_int_reg;

	// serial clock enable: every cycle after reset, every second cycle when halved
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			div2_reg <= SER_DIV2_RST;
			div_phase_reg <= 1'b0;
		end else begin
			div2_reg <= SER_DIV2_REQ; // [RULE18]
			div_phase_reg <= !div_phase_reg;
		end
	end
	assign SER_CLK_ENABLE = !div2_reg || div_phase_reg; // [RULE18]
endmodule : emc_pin_ctrl
`default_nettype wire

// File: emc_pkg.sv
`default_nettype none
package emc_pkg;
	// mode select encodings {high, low}
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_ADAPTER = 2'h1;
	localparam logic [1:0] MODE_PROBE = 2'h2;
	localparam logic [1:0] MODE_TEST = 2'h3;
	// internal reset stretch length in core clocks (one-shot)
	localparam int RESET_STRETCH_CYCLES = 16;
	// host receive interrupt set/clear limits in processor clocks
	localparam int RX_INT_SET_MAX = 2;
	localparam int RX_INT_CLR_MAX = 2;
	// bus widths
	localparam int ADDR_W = 20;
	localparam int ADDR18_BIT = 18;
	localparam int DATA_W = 8;
	// serial clock divider reset value: undivided
	localparam logic SER_DIV2_RST = 1'b0;
endpackage : emc_pkg
`default_nettype wire

// File: emc_reset_oneshot.sv
`default_nettype none
module emc_reset_oneshot
	import emc_pkg::*;
#(
	parameter int STRETCH = RESET_STRETCH_CYCLES
) (
	// clock and external reset
	input wire logic clk,
	input wire logic nrst,
	// bypass selects the direct path
	input wire logic bypass,
	// stretched internal reset, active low
	output logic int_rst_n
);
	// elaboration check: a zero-length stretch would let reset through unstretched
	if (STRETCH < 1) begin : g_bad_stretch
		$error("stretch must be at least one cycle");
	end

	localparam int CW = $clog2(STRETCH + 1);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic done;

	// count after release; reset restarts the count so every pulse lasts STRETCH
	assign done = (cnt_reg == CW'(STRETCH));
	assign cnt_next = done ? cnt_reg : cnt_reg + CW'(1);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// adapter path follows the pin directly, normal path is held until count ends
	assign int_rst_n = bypass ? nrst : (nrst & done);
endmodule : emc_reset_oneshot
`default_nettype wire

// File: emc_pin_ctrl_checker.sv
`default_nettype none
module emc_pin_ctrl_checker
	import emc_pkg::*;
(
	// clock, reset and inputs
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic MODE_SELECT_LOW,
	input wire logic MODE_SELECT_HIGH,
	input wire logic CPU_SLEEP,
	input wire logic CPU_HALT,
	input wire logic MUX_MEM_STROBES,
	input wire logic MUX_IO_SELECT,
	input wire logic ADDR18_AS_ADDR,
	input wire logic CORE_INT0_PULL,
	input wire logic HOST_RX_STOP,
	input wire logic HOST_READ_STROBE_N,
	input wire logic HOST_READ_RX_OR_STATUS,
	// watched outputs
	input wire logic [emc_pkg::ADDR_W-1:0] ADDR_OE,
	input wire logic [emc_pkg::DATA_W-1:0] DATA_OE,
	input wire logic RD_N_OE,
	input wire logic WR_N_OE,
	input wire logic MEMORY_READ_STROBE_O,
	input wire logic MEMORY_READ_STROBE_OE,
	input wire logic MEMORY_WRITE_STROBE_O,
	input wire logic ROM_SELECT_O,
	input wire logic RAM_SELECT_O,
	input wire logic IO_SELECT_OE,
	input wire logic INT0_O,
	input wire logic INT0_OE,
	input wire logic OSC_ENABLE,
	input wire logic INT_RESET_N,
	input wire logic HOST_EMU_ENABLE,
	input wire logic HOST_RX_INT
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] mode;
	logic pd, up;
	logic [4:0] cnt_reg;
	// the mode register loads on the first edge, so checks wait two edges
	assign mode = {MODE_SELECT_HIGH, MODE_SELECT_LOW};
	assign pd = CPU_SLEEP | CPU_HALT;
	assign up = cnt_reg >= 5'h2;
	// saturating count of edges since reset release
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) cnt_reg <= 5'h0;
		else if (cnt_reg != 5'h1f) cnt_reg <= cnt_reg + 5'h1;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	a_probe_all_float: assert property (up && mode == MODE_PROBE |->
		ADDR_OE == '0 && DATA_OE == '0 && !RD_N_OE && !INT0_OE) else $error("probe mode drives a pin");
	a_adapter_release: assert property (up && mode == MODE_ADAPTER |->
		!RD_N_OE && !WR_N_OE && !MEMORY_READ_STROBE_OE && ADDR_OE == '0) else $error("adapter keeps cpu pin");
	a_osc_mode: assert property (up |-> OSC_ENABLE == (mode == MODE_NORMAL))
		else $error("oscillator enable wrong");
	a_int0_open_drain: assert property (up |-> !INT0_O &&
		INT0_OE == (mode == MODE_ADAPTER && CORE_INT0_PULL)) else $error("int0 drive wrong");
	a_sleep_selects_high: assert property (up && pd |-> ROM_SELECT_O && RAM_SELECT_O &&
		(!MUX_MEM_STROBES || (MEMORY_READ_STROBE_O && MEMORY_WRITE_STROBE_O))) else $error("select not high");
	a_sleep_bus_float: assert property (up && pd |-> !RD_N_OE && !WR_N_OE && DATA_OE == '0 &&
		(ADDR_OE & {1'b1, ADDR18_AS_ADDR, 18'h3ffff}) == '0 && !(MUX_IO_SELECT && IO_SELECT_OE))
		else $error("bus driven in power-down");
	a_host_off_pd: assert property (up && pd |-> !HOST_EMU_ENABLE)
		else $error("host logic on in power-down");
	a_rx_int_set: assert property (up && HOST_RX_STOP && HOST_EMU_ENABLE && !pd && !mode[1] |->
		##[1:2] HOST_RX_INT) else $error("rx interrupt late");
	a_rx_int_clear: assert property (up && !HOST_READ_STROBE_N && HOST_READ_RX_OR_STATUS && !HOST_RX_STOP |->
		##[1:2] !HOST_RX_INT) else $error("rx interrupt not cleared");
	a_reset_stretch: assert property (mode == MODE_NORMAL && cnt_reg == 5'h2 |->
		!INT_RESET_N ##13 !INT_RESET_N ##1 INT_RESET_N) else $error("reset stretch wrong");
	a_reset_bypass: assert property (mode == MODE_ADAPTER && cnt_reg == 5'h2 |-> INT_RESET_N)
		else $error("reset not bypassed");
endmodule : emc_pin_ctrl_checker
bind emc_pin_ctrl emc_pin_ctrl_checker i_emc_pin_ctrl_checker (.*);
`default_nettype wire

// File: emc_board_model.sv
`default_nettype none
module emc_board_model (
	// wanted mode and emulator drive
	input wire logic [1:0] mode,
	input wire logic emu_memory_request,
	// device pins seen by the board
	input wire logic int0_o,
	input wire logic int0_oe,
	input wire logic mrd_o,
	input wire logic mrd_oe,
	// straps and resolved lines
	output logic sel_low,
	output logic sel_high,
	output logic int0_lvl,
	output logic memory_request_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// straps follow the bench, but the reserved code is never put out
	assign {sel_high, sel_low} = (mode == 2'h3) ? 2'h0 : mode;
	// pulled-up interrupt line, pulled low only by the device
	assign int0_lvl = (int0_oe && !int0_o) ? 1'b0 : 1'b1;
	// emulator owns the shared strobe pin whenever the device lets go
	assign memory_request_pin = mrd_oe ? mrd_o : emu_memory_request;
endmodule : emc_board_model
`default_nettype wire

// File: test_emulation_mode_pin_control.sv
`default_nettype none
module test_emulation_mode_pin_control;
	timeunit 1ns;
	timeprecision 1ps;
	import emc_pkg::*;
	logic CORE_CLK, NRST, MODE_SELECT_LOW, MODE_SELECT_HIGH, CPU_SLEEP, CPU_HALT, MUX_MEM_STROBES, MUX_IO_SELECT;
	logic ADDR18_AS_ADDR, CORE_ADDR_OE, CORE_DATA_OE, CORE_TIMER_OUT, CORE_RD_N, CORE_WR_N, CORE_CTRL_OE;
	logic CORE_MEM_READ_STROBE_N, CORE_MEM_WRITE_STROBE_N, CORE_ROM_SELECT_N, CORE_RAM_SELECT_N, CORE_IO_SELECT_N;
	logic CORE_SERIAL_TX, CORE_INT0_PULL, HOST_RX_STOP, HOST_READ_STROBE_N, HOST_READ_RX_OR_STATUS, SER_DIV2_REQ;
	logic [ADDR_W-1:0] CORE_ADDR, ADDR_O, ADDR_OE;
	logic [DATA_W-1:0] CORE_DATA, DATA_O, DATA_OE;
	logic RD_N_O, RD_N_OE, WR_N_O, WR_N_OE, MEMORY_READ_STROBE_O, MEMORY_READ_STROBE_OE, MEMORY_WRITE_STROBE_O;
	logic MEMORY_WRITE_STROBE_OE, ROM_SELECT_O, ROM_SELECT_OE, RAM_SELECT_O, RAM_SELECT_OE, IO_SELECT_O, IO_SELECT_OE;
	logic SERIAL_TX_O, SERIAL_TX_OE, INT0_O, INT0_OE, OSC_ENABLE, INT_RESET_N, HOST_EMU_ENABLE, HOST_RX_INT;
	logic SER_CLK_ENABLE, emu_memory_request, int0_lvl, memory_request_pin;
	logic [1:0] mode;
	int failures, checks_done, n;
	// 125 MHz core clock
	initial begin
		CORE_CLK = 1'b0;
		forever #4 CORE_CLK = ~CORE_CLK;
	end
	emc_pin_ctrl i_emc_pin_ctrl (.*);
	emc_board_model i_emc_board_model (.mode(mode), .emu_memory_request(emu_memory_request), .int0_o(INT0_O), .int0_oe(INT0_OE),
		.mrd_o(MEMORY_READ_STROBE_O), .mrd_oe(MEMORY_READ_STROBE_OE), .sel_low(MODE_SELECT_LOW),
		.sel_high(MODE_SELECT_HIGH), .int0_lvl(int0_lvl), .memory_request_pin(memory_request_pin));
	// pull-up wins unless the adapter-mode device pulls
	function automatic logic lvl_int0(input logic pull);
		return !pull;
	endfunction : lvl_int0
	task automatic chk(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %b seen %b", name, exp, got);
		end
	endtask : chk
	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk_word
	// address pin word: bit 18 shows the timer unless the pin is selected as address
	function automatic logic [ADDR_W-1:0] exp_addr(input logic [ADDR_W-1:0] a, input logic sel, input logic tmr);
		logic [ADDR_W-1:0] r;
		r = a;
		r[ADDR18_BIT] = sel ? a[ADDR18_BIT] : tmr;
		return r;
	endfunction : exp_addr
	// inputs move 1 ns after the edge so no race with the design's flops
	task automatic cyc(input int k);
		repeat (k) @(posedge CORE_CLK);
		#1;
	endtask : cyc
	task automatic rnd();
		{CPU_SLEEP, CPU_HALT, MUX_MEM_STROBES, MUX_IO_SELECT, ADDR18_AS_ADDR, CORE_ADDR_OE, CORE_DATA_OE,
			CORE_TIMER_OUT, CORE_RD_N, CORE_WR_N, CORE_CTRL_OE, CORE_MEM_READ_STROBE_N, CORE_MEM_WRITE_STROBE_N,
			CORE_ROM_SELECT_N, CORE_RAM_SELECT_N, CORE_IO_SELECT_N, CORE_SERIAL_TX, CORE_INT0_PULL,
			emu_memory_request} = 19'($urandom);
		CORE_ADDR = 20'($urandom);
		CORE_DATA = 8'($urandom);
	endtask : rnd
	// straps only change while reset is held, as a board would
	task automatic rst(input logic [1:0] m);
		NRST = 1'b0;
		mode = m;
		cyc(10);
		NRST = 1'b1;
		cyc(24);
	endtask : rst
	task automatic rx_pulse();
		cyc(2);
		HOST_RX_STOP = 1'b1;
		cyc(1);
		HOST_RX_STOP = 1'b0;
		cyc(1);
	endtask : rx_pulse
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// cut a hang short well past the expected run time
	initial begin
		#20000;
		failures++;
		print_verdict();
	end
	// main sequence: every usable mode, random pins, host interrupt, divider
	initial begin
		NRST = 1'b0;
		mode = 2'h0;
		HOST_RX_STOP = 1'b0;
		HOST_READ_STROBE_N = 1'b1;
		HOST_READ_RX_OR_STATUS = 1'b1;
		SER_DIV2_REQ = 1'b0;
		n = $urandom(16);
		rnd();
		for (int m = 0; m < 3; m++) begin
			rst(2'(m));
			chk("osc", m == 0, OSC_ENABLE);
			chk("int_rst", 1'b1, INT_RESET_N);
			chk("ser_clk", 1'b1, SER_CLK_ENABLE);
			repeat (40) begin
				rnd();
				cyc(1);
				if (m == 1) chk("int0", lvl_int0(CORE_INT0_PULL), int0_lvl);
				if (m == 1) chk("memory_request", emu_memory_request, memory_request_pin);
				if (m == 2) chk("probe_oe", 1'b1, ADDR_OE === '0 && DATA_OE === '0);
				if (m == 0 && (CPU_SLEEP || CPU_HALT)) chk("rom_sel", 1'b1, ROM_SELECT_O);
				chk_word("addr_o", 32'(exp_addr(CORE_ADDR, ADDR18_AS_ADDR, CORE_TIMER_OUT)), 32'(ADDR_O));
				chk_word("data_o", 32'(CORE_DATA), 32'(DATA_O));
				chk("rd_oe", m == 0 && CORE_CTRL_OE && !(CPU_SLEEP || CPU_HALT), RD_N_OE);
				chk("tx_oe", m == 0, SERIAL_TX_OE);
				chk("sel_oe", 1'b1, ROM_SELECT_OE == (m != 2) && RAM_SELECT_OE == (m != 2));
				chk("io_oe", m != 2 && MUX_IO_SELECT && !(CPU_SLEEP || CPU_HALT), IO_SELECT_OE);
				chk("mwr_oe", m != 2 && MUX_MEM_STROBES, MEMORY_WRITE_STROBE_OE);
				chk("pass", 1'b1, {RD_N_O, WR_N_O, IO_SELECT_O, SERIAL_TX_O} ===
					{CORE_RD_N, CORE_WR_N, CORE_IO_SELECT_N, CORE_SERIAL_TX});
			end
			CPU_SLEEP = 1'b0;
			CPU_HALT = 1'b0;
			rx_pulse();
			chk("rx_set", m != 2, HOST_RX_INT);
			// a host read of some other register leaves the interrupt alone
			HOST_READ_RX_OR_STATUS = 1'b0;
			HOST_READ_STROBE_N = 1'b0;
			cyc(1);
			HOST_READ_STROBE_N = 1'b1;
			HOST_READ_RX_OR_STATUS = 1'b1;
			cyc(1);
			chk("rx_other", m != 2, HOST_RX_INT);
			HOST_READ_STROBE_N = 1'b0;
			cyc(1);
			HOST_READ_STROBE_N = 1'b1;
			cyc(1);
			chk("rx_clr", 1'b0, HOST_RX_INT);
			// stop and clearing read in one cycle: the new character wins
			HOST_RX_STOP = 1'b1;
			HOST_READ_STROBE_N = 1'b0;
			cyc(1);
			HOST_RX_STOP = 1'b0;
			HOST_READ_STROBE_N = 1'b1;
			cyc(1);
			chk("rx_both", m != 2, HOST_RX_INT);
			CPU_HALT = 1'b1;
			rx_pulse();
			chk("rx_pd", 1'b0, HOST_RX_INT);
		end
		rst(2'h0);
		SER_DIV2_REQ = 1'b1;
		cyc(2);
		n = 0;
		repeat (8) begin
			n = n + int'(SER_CLK_ENABLE);
			cyc(1);
		end
		chk("ser_div", 1'b1, n == 4);
		print_verdict();
	end
endmodule : test_emulation_mode_pin_control
`default_nettype wire
